/* mfe_feature_enable.v */
`include "mfe_defines.vh"
module mfe_feature_enable #(
    parameter TTC_W = 16
) (
    // Clock and reset.
    input wire core_clk,
    input wire sys_rst,
    // Register port.
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Unit status inputs, all from outside this clock domain.
    input wire thermal_hot,
    input wire break_pending,
    input wire legacy_fp_error,
    input wire bts_unavail,
    input wire pebs_unavail,
    input wire [TTC_W-1:0] nominal_voltage_ratio,
    // Outputs to the rest of the core.
    output reg float_error_pin,
    output reg [TTC_W-1:0] voltage_ratio_out,
    output reg thermal_monitor_freq_volt_active,
    output reg thermal_monitor_clock_mod_active,
    output reg dvfs_enable,
    output reg monitor_wait_engine_enable,
    output reg [7:0] line_fill_bytes
);
    // Software visible low word and thermal target field.
    reg [31:0] enable_reg; // Stored controls of bits 31:0.
    reg [31:0] enable_next; // Value the low word takes at the next edge.
    reg [TTC_W-1:0] target_reg; // Last written thermal target.
    reg [TTC_W-1:0] target_next; // Value the target takes next.
    // Write strobes decoded per register.
    wire lo_wr_hit; // Write to the low control word.
    wire ttc_wr_hit; // Write to the thermal target register.
    // Thermal decisions, ahead of their output flip-flops.
    wire freq_volt_engage; // Second monitor wanted this cycle.
    wire clock_mod_engage; // First monitor wanted this cycle.
    // Synchronised views of the pin inputs.
    wire hot_s;
    wire brk_s;
    wire fperr_s;
    wire bts_s;
    wire pebs_s;
    wire [TTC_W-1:0] nom_s;

    // Single bit pins pass two flip-flops before use.
    // Die temperature at its threshold.
    mfe_sync2 u_sync_hot (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(thermal_hot),
        .sync_out(hot_s)
    );
    // Break event pending inside the core.
    mfe_sync2 u_sync_brk (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(break_pending),
        .sync_out(brk_s)
    );
    // Legacy floating-point error level.
    mfe_sync2 u_sync_fpe (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(legacy_fp_error),
        .sync_out(fperr_s)
    );
    // Branch trace storage unavailable flag.
    mfe_sync2 u_sync_bts (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(bts_unavail),
        .sync_out(bts_s)
    );
    // Event sampling unavailable flag.
    mfe_sync2 u_sync_pebs (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(pebs_unavail),
        .sync_out(pebs_s)
    );

    // The nominal setting is quasi-static; one synchroniser per bit.
    // A change may show mixed bits for one cycle before it settles.
    genvar gi;
    generate
        for (gi = 0; gi < TTC_W; gi = gi + 1) begin : g_nom
            mfe_sync2 u_sync_nom (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .async_in(nominal_voltage_ratio[gi]),
                .sync_out(nom_s[gi])
            );
        end
    endgenerate

    // Address decode of the write strobe; other addresses are ignored.
    assign lo_wr_hit = reg_wr && (reg_addr == `MFE_ADDR_LO);
    assign ttc_wr_hit = reg_wr && (reg_addr == `MFE_ADDR_TTC);

    // The second monitor has priority; the first acts only without it.
    assign freq_volt_engage = enable_reg[`MFE_BIT_FREQ_VOLT] & hot_s;
    assign clock_mod_engage = enable_reg[`MFE_BIT_CLK_MOD]
        & ~enable_reg[`MFE_BIT_FREQ_VOLT] & hot_s;

    // Next values: only writable bits and mapped addresses take data.
    always @* begin
        enable_next = enable_reg;
        target_next = target_reg;
        if (lo_wr_hit) begin
            // Read-only flags and reserved bits are never stored.
            enable_next = reg_wdata & `MFE_WMASK;
        end
        if (ttc_wr_hit) begin
            // The last written target is held for the second monitor.
            target_next = reg_wdata[TTC_W-1:0];
        end
    end

    // Register storage, cleared by reset.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            enable_reg <= `MFE_RESET_LO;
            target_reg <= `MFE_RESET_TTC;
        end else begin
            // Every edge loads the next value; holding is in the next logic.
            enable_reg <= enable_next;
            target_reg <= target_next;
        end
    end

    // Read data stands one cycle after the read strobe, else zero.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `MFE_ADDR_LO: begin
                    // Flags reflect unit state; reserved read zero.
                    reg_rdata <= enable_reg
                        | ({31'h0000_0000, bts_s} << `MFE_BIT_BTS_NA)
                        | ({31'h0000_0000, pebs_s} << `MFE_BIT_PEBS_NA);
                end
                `MFE_ADDR_TTC: begin
                    reg_rdata <= {{(32-TTC_W){1'b0}}, target_reg};
                end
                `MFE_ADDR_STAT: begin
                    // Live state of the thermal machinery.
                    reg_rdata <= {29'h0000_0000, hot_s,
                        thermal_monitor_clock_mod_active,
                        thermal_monitor_freq_volt_active};
                end
                default: begin
                    // Upper word and unmapped addresses read zero.
                    reg_rdata <= 32'h0000_0000;
                end
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Feature outputs, each driven from a flip-flop.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            // Reset leaves every feature off and the full pair fill.
            float_error_pin <= 1'b0;
            voltage_ratio_out <= {TTC_W{1'b0}};
            thermal_monitor_freq_volt_active <= 1'b0;
            thermal_monitor_clock_mod_active <= 1'b0;
            dvfs_enable <= 1'b0;
            monitor_wait_engine_enable <= 1'b0;
            line_fill_bytes <= `MFE_PAIR_BYTES;
        end else begin
            // Error pin source selected by the mux bit.
            if (enable_reg[`MFE_BIT_ERR_MUX]) begin
                // Break pending is shown on the pin.
                float_error_pin <= brk_s;
            end else begin
                // Compatible behaviour follows the legacy error level.
                float_error_pin <= fperr_s;
            end
            // Second monitor lowers ratio and voltage to the target.
            thermal_monitor_freq_volt_active <= freq_volt_engage;
            if (freq_volt_engage) begin
                voltage_ratio_out <= target_reg;
            end else begin
                // With bit 13 clear the nominal setting is kept.
                voltage_ratio_out <= nom_s;
            end
            // First monitor engages only without the second.
            thermal_monitor_clock_mod_active <= clock_mod_engage;
            // Scaling enable is a plain copy of bit 16.
            dvfs_enable <= enable_reg[`MFE_BIT_DVFS];
            // Monitor/wait engine enable is a plain copy of bit 18.
            monitor_wait_engine_enable <= enable_reg[`MFE_BIT_MON_WAIT];
            // Fill size follows the adjacent line prefetch disable bit.
            if (enable_reg[`MFE_BIT_ADJ_DIS]) begin
                // Only the line holding the needed data.
                line_fill_bytes <= `MFE_LINE_BYTES;
            end else begin
                // Both lines of the aligned pair.
                line_fill_bytes <= `MFE_PAIR_BYTES;
            end
        end
    end
endmodule // mfe_feature_enable

/* mfe_defines.vh */
`ifndef MFE_DEFINES_VH
`define MFE_DEFINES_VH
// Register offsets on the plain register port (word addresses).
`define MFE_ADDR_LO 4'h0
`define MFE_ADDR_HI 4'h1
`define MFE_ADDR_TTC 4'h2
`define MFE_ADDR_STAT 4'h3
// Bit positions within the low word of the feature enable register.
`define MFE_BIT_CLK_MOD 3
`define MFE_BIT_ERR_MUX 10
`define MFE_BIT_BTS_NA 11
`define MFE_BIT_PEBS_NA 12
`define MFE_BIT_FREQ_VOLT 13
`define MFE_BIT_DVFS 16
`define MFE_BIT_MON_WAIT 18
`define MFE_BIT_ADJ_DIS 19
// Writable bits of the low word covered here.
`define MFE_WMASK 32'h000d_2408
// Reset value of the low word: all covered controls clear.
`define MFE_RESET_LO 32'h0000_0000
// Reset value of the thermal target field.
`define MFE_RESET_TTC 16'h0000
// Line size and fill sizes in bytes.
`define MFE_LINE_BYTES 8'h40
`define MFE_PAIR_BYTES 8'h80
`endif

/* mfe_sync2.v */
// Two flip-flop synchroniser for one level from outside the clock domain.
module mfe_sync2 (
    // Clock and reset.
    input wire core_clk,
    input wire sys_rst,
    // Asynchronous level in and synchronised level out.
    input wire async_in,
    output reg sync_out
);
    // First stage, read only by the second stage.
    reg meta_reg;

    // Two stages clear on reset, then follow the input.
    always @(posedge core_clk) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // mfe_sync2

/* mfe_checker_assertions.sv */
// Watches the register port and feature outputs of the enable block.
module mfe_checker (
    // Clock and reset.
    input wire core_clk,
    input wire sys_rst,
    // Register port.
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Feature outputs.
    input wire thermal_monitor_freq_volt_active,
    input wire thermal_monitor_clock_mod_active,
    input wire dvfs_enable,
    input wire monitor_wait_engine_enable,
    input wire [7:0] line_fill_bytes
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // A low word write with no second low word write right behind it.
    sequence lo_wr_s;
        reg_wr && reg_addr == 4'h0 ##1 !(reg_wr && reg_addr == 4'h0);
    endsequence
    ctrl_follow_a: assert property (lo_wr_s |=>
        dvfs_enable == $past(reg_wdata[16], 2) &&
        monitor_wait_engine_enable == $past(reg_wdata[18], 2))
        else $error("control outputs do not follow the written bits.");
    fill_size_a: assert property (lo_wr_s |=>
        line_fill_bytes == ($past(reg_wdata[19], 2) ? 8'h40 : 8'h80))
        else $error("line fill size does not follow the written bit.");
    fv_mon_off_a: assert property (reg_wr && reg_addr == 4'h0 &&
        !reg_wdata[13] ##1 !(reg_wr && reg_addr == 4'h0)
        |=> !thermal_monitor_freq_volt_active)
        else $error("second monitor active while disabled.");
    monitor_excl_a: assert property (
        thermal_monitor_freq_volt_active |->
        !thermal_monitor_clock_mod_active)
        else $error("both thermal monitors active.");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read.");
    reserved_zero_a: assert property (reg_rd && reg_addr == 4'h0
        |=> (reg_rdata & 32'hfff2c3f7) == 32'h0)
        else $error("reserved bits read as nonzero.");
    high_word_a: assert property (reg_rd && reg_addr == 4'h1
        |=> reg_rdata == 32'h0)
        else $error("high word reads nonzero.");
    fill_legal_a: assert property (line_fill_bytes == 8'h40 ||
        line_fill_bytes == 8'h80)
        else $error("line fill size is neither one line nor a pair.");
endmodule // mfe_checker
bind mfe_feature_enable mfe_checker u_chk (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .thermal_monitor_freq_volt_active(thermal_monitor_freq_volt_active),
    .thermal_monitor_clock_mod_active(thermal_monitor_clock_mod_active),
    .dvfs_enable(dvfs_enable),
    .monitor_wait_engine_enable(monitor_wait_engine_enable),
    .line_fill_bytes(line_fill_bytes));

/* misc_feature_enable_bits_bench.sv */
module misc_feature_enable_bits_bench;
    timeunit 1ns;
    timeprecision 1ps;
    reg core_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0, reg_rd = 1'b0, hot = 1'b0, brk = 1'b0, leg = 1'b0;
    reg bts = 1'b0, pebs = 1'b0;
    reg [15:0] nom = 16'habcd;
    wire [31:0] rdata;
    wire fe_pin, fv_act, cm_act, dvfs, mwe;
    wire [15:0] vr;
    wire [7:0] fill;
    integer bad_count = 0, checks = 0;
    always #4 core_clk = ~core_clk;
    mfe_feature_enable DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .thermal_hot(hot),
        .break_pending(brk), .legacy_fp_error(leg), .bts_unavail(bts),
        .pebs_unavail(pebs), .nominal_voltage_ratio(nom),
        .float_error_pin(fe_pin), .voltage_ratio_out(vr),
        .thermal_monitor_freq_volt_active(fv_act),
        .thermal_monitor_clock_mod_active(cm_act), .dvfs_enable(dvfs),
        .monitor_wait_engine_enable(mwe), .line_fill_bytes(fill));
    // Counts a comparison and reports a mismatch at once.
    task chk(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // Lets n edges pass so synchronisers and outputs settle.
    task tick(input integer n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task rd(input [3:0] a, input [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task t_mask;
        tick(1);
        chk({24'h0, fill}, 32'h80);
        rd(4'h0, 32'h0);
        wr(4'h0, 32'hffffffff);
        tick(2);
        chk({30'h0, dvfs, mwe}, 32'h3);
        chk({24'h0, fill}, 32'h40);
        rd(4'h0, 32'h000d2408);
        wr(4'h1, 32'hffffffff);
        rd(4'h1, 32'h0);
        rd(4'h9, 32'h0);
    endtask
    task t_flags;
        @(posedge core_clk);
        bts <= 1'b1;
        pebs <= 1'b1;
        wr(4'h0, 32'h8);
        tick(4);
        rd(4'h0, 32'h1808);
        chk({24'h0, fill}, 32'h80);
    endtask
    task t_pin;
        @(posedge core_clk);
        leg <= 1'b1;
        tick(5);
        chk(fe_pin, 1'b1);
        wr(4'h0, 32'h408);
        tick(2);
        chk(fe_pin, 1'b0);
        @(posedge core_clk);
        brk <= 1'b1;
        tick(5);
        chk(fe_pin, 1'b1);
    endtask
    task t_therm;
        wr(4'h2, 32'h1234);
        wr(4'h0, 32'h2008);
        @(posedge core_clk);
        hot <= 1'b1;
        tick(5);
        chk({14'h0, fv_act, cm_act, vr}, 32'h21234);
        rd(4'h2, 32'h1234);
        rd(4'h3, 32'h5);
        wr(4'h0, 32'h8);
        tick(2);
        chk({14'h0, fv_act, cm_act, vr}, 32'h1abcd);
    endtask
    task wrap_up;
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_mask;
        t_flags;
        t_pin;
        t_therm;
        wrap_up;
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        #5000;
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule // misc_feature_enable_bits_bench
